// [bench/rtc_core_asserts.sv]
// concurrent checks on the switch core control ports
`timescale 1ns/1ps
`default_nettype none
module rtc_core_asserts
#(
  parameter int SCRUB_PERIOD = 16
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // watched ports
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_q,
  input wire logic [rtc_pkg::NPORT-1:0] tc_in_valid,
  input wire logic [rtc_pkg::NPORT-1:0][rtc_pkg::NPORT-1:0] alloc_q,
  input wire logic [rtc_pkg::NPORT-1:0] spill_q,
  input wire logic [rtc_pkg::NPORT-1:0] eep_q,
  input wire logic [rtc_pkg::NPORT-1:0] invalid_addr_q,
  input wire logic [rtc_pkg::NPORT-1:0] tc_out_valid_q,
  input wire logic tick_q,
  input wire logic scrub_strobe_q,
  input wire logic [7:0] scrub_addr_q
);
  import rtc_pkg::*;
  logic [NPORT-1:0] held;
  logic [NPORT-1:0] alloc_any;
  logic seen_q;
  logic [7:0] last_q;
  always_comb
  begin
    held = '0;
    alloc_any = '0;
    for (int s = 0; s < NPORT; s++)
    begin
      held[s] = |alloc_q[s];
      alloc_any = alloc_any | alloc_q[s];
    end
  end
  // remembers the previous scrub address so the walk order can be checked
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      seen_q <= 1'b0;
      last_q <= 8'h00;
    end
    else if (scrub_strobe_q)
    begin
      seen_q <= 1'b1;
      last_q <= scrub_addr_q;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata_q == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_inv_spill;
    (invalid_addr_q & ~spill_q) == '0;
  endproperty
  a_inv_spill: assert property (p_inv_spill)
    else $error("invalid address without discard");
  property p_tc_tick;
    |tc_out_valid_q |-> tick_q;
  endproperty
  a_tc_tick: assert property (p_tc_tick)
    else $error("time-code sent without tick");
  property p_tick_cause;
    tick_q |-> $past(|tc_in_valid);
  endproperty
  a_tick_cause: assert property (p_tick_cause)
    else $error("tick without incoming time-code");
  property p_eep_alloc;
    |eep_q |-> (eep_q & ~$past(alloc_any)) == '0;
  endproperty
  a_eep_alloc: assert property (p_eep_alloc)
    else $error("error marker on a port not carrying the packet");
  property p_spill_free;
    |spill_q |=> (held & $past(spill_q)) == '0;
  endproperty
  a_spill_free: assert property (p_spill_free)
    else $error("ports still held after discard");
  property p_scrub_step;
    scrub_strobe_q |-> scrub_addr_q == (seen_q ? last_q + 8'h01 : 8'h00);
  endproperty
  a_scrub_step: assert property (p_scrub_step)
    else $error("scrub address out of order");
  property p_scrub_gap;
    scrub_strobe_q |=> !scrub_strobe_q [*8];
  endproperty
  a_scrub_gap: assert property (p_scrub_gap)
    else $error("scrub refreshes too close");
  c_tick: cover property (tick_q);
  c_eep: cover property (|eep_q);
  c_scrub: cover property (scrub_strobe_q);
endmodule
`default_nettype wire

// [bench/rtc_link_model.sv]
// far-side link codec model: run state made in the link clock domain
`timescale 1ns/1ps
`default_nettype none
module rtc_link_model
#(
  parameter int START_DELAY = 64
)
(
  // link clock and reset
  input wire logic link_clk,
  input wire logic reset,
  // bench control and start requests from the core
  input wire logic [rtc_pkg::NPORT-1:0] run_req,
  input wire logic [rtc_pkg::NPORT-1:0] start_req,
  // run state towards the core
  output logic [rtc_pkg::NPORT-1:0] link_running
);
  import rtc_pkg::*;
  int wait_q [NPORT];
  // a requested start takes START_DELAY+1 link clocks; a slow link
  // outlives the core's timeout on purpose
  always_ff @(posedge link_clk or posedge reset)
  begin
    if (reset)
    begin
      link_running <= '0;
      for (int p = 0; p < NPORT; p++)
        wait_q[p] <= 0;
    end
    else
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        wait_q[p] <= (start_req[p] && !run_req[p]) ? wait_q[p] + 1 : 0;
        link_running[p] <= run_req[p] || (wait_q[p] >= START_DELAY);
      end
    end
  end
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the switch core control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rtc_pkg::*;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [NPORT-1:0] hdr_valid = '0;
  rtc_hdr_t [NPORT-1:0] hdr = '0;
  logic [NPORT-1:0] char_tx = '0;
  logic [NPORT-1:0] pkt_done = '0;
  logic [NPORT-1:0] tc_in_valid = '0;
  rtc_tc_t [NPORT-1:0] tc_in = '0;
  // port 4 stays stopped for the not-running cases
  logic [NPORT-1:0] run_req = 13'h1FEF;
  logic [NPORT-1:0] link_running, spill_q, eep_q, link_start_q;
  logic [NPORT-1:0] invalid_addr_q, tc_out_valid_q;
  logic [NPORT-1:0][NPORT-1:0] alloc_q;
  logic [31:0] reg_rdata_q;
  rtc_tc_t tc_out_q;
  logic tick_q, scrub_strobe_q;
  logic [7:0] scrub_addr_q;
  int err_total = 0;
  int checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  always #40 link_clk = ~link_clk;
  rtc_core #(.SCRUB_PERIOD(16)) u_rtc_core (.sys_clk(sys_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .hdr_valid(hdr_valid), .hdr(hdr), .char_tx(char_tx),
    .pkt_done(pkt_done), .link_running(link_running), .alloc_q(alloc_q),
    .spill_q(spill_q), .eep_q(eep_q), .link_start_q(link_start_q),
    .invalid_addr_q(invalid_addr_q), .tc_in_valid(tc_in_valid),
    .tc_in(tc_in), .tc_out_valid_q(tc_out_valid_q), .tc_out_q(tc_out_q),
    .tick_q(tick_q), .scrub_strobe_q(scrub_strobe_q),
    .scrub_addr_q(scrub_addr_q));
  rtc_link_model u_rtc_link_model (.link_clk(link_clk), .reset(reset),
    .run_req(run_req), .start_req(link_start_q),
    .link_running(link_running));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata_q", e, reg_rdata_q);
  endtask
  function automatic rtc_hdr_t mk(input logic p, input logic [4:0] pt,
    input logic [1:0] ok, input logic [12:0] st, input logic me);
    return rtc_hdr_t'({p, pt, ok, st, me});
  endfunction
  task automatic send(input int s, input rtc_hdr_t h);
    @(posedge sys_clk);
    hdr[s] <= h;
    hdr_valid[s] <= 1'b1;
    @(posedge sys_clk);
    hdr_valid[s] <= 1'b0;
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(REG_CFG, 32'h63);
    rd(REG_TMO_BASE, 32'hFF);
    rd(REG_TIMER_EN, 32'h0);
    rd(REG_TC_EN, 32'h1FFF);
    rd(8'h30, 32'h0);
    for (int p = 0; p < NPORT; p++)
      wr(8'(REG_TMO_BASE + 4 * p), 32'h4);
    rd(8'h70, 32'h4);
  endtask
  task automatic tc(input int p, input logic [7:0] v, input logic t,
    input logic [12:0] m);
    @(posedge sys_clk);
    tc_in[p] <= v;
    tc_in_valid[p] <= 1'b1;
    @(posedge sys_clk);
    tc_in_valid[p] <= 1'b0;
    // tick and port mask stand only in the cycle after the code
    #1;
    chk("tick_q", 32'(t), 32'(tick_q));
    if (t)
    begin
      chk("tc_out_valid_q", 32'(m), 32'(tc_out_valid_q));
      chk("tc_out_q", 32'(v), 32'(tc_out_q));
    end
  endtask
  task automatic t_tc;
    tc(2, 8'h01, 1'b1, 13'h1FFB);
    tc(9, 8'h02, 1'b1, 13'h1DFF);
    tc(2, 8'h05, 1'b0, 13'h0);
    tc(2, 8'h06, 1'b1, 13'h1FFB);
    wr(REG_CFG, 32'h00010063);
    tc(2, 8'h47, 1'b0, 13'h0);
    tc(2, 8'h07, 1'b1, 13'h1FFB);
    wr(REG_TC_EN, 32'h1FF7);
    tc(3, 8'h08, 1'b0, 13'h0);
    tc(2, 8'h08, 1'b1, 13'h1FF3);
    rd(REG_TIMECODE, 32'h08);
  endtask
  task automatic bad(input rtc_hdr_t h, input logic inv);
    int n;
    send(5, h);
    for (n = 0; n < 4 && spill_q[5] !== 1'b1; n++)
      step;
    chk("spill_q", 32'h1, 32'(spill_q[5]));
    if (inv)
      chk("invalid_addr_q", 32'h1, 32'(invalid_addr_q[5]));
  endtask
  task automatic t_bad;
    bad(mk(1'b1, 5'd13, 2'h0, 13'h0, 1'b0), 1'b1);
    bad(mk(1'b0, 5'd0, 2'h1, 13'h2, 1'b0), 1'b1);
    bad(mk(1'b0, 5'd0, 2'h2, 13'h2, 1'b0), 1'b1);
    bad(mk(1'b0, 5'd0, 2'h3, 13'h2, 1'b1), 1'b0);
    rd(REG_STATUS, 32'h3);
    wr(REG_STATUS, 32'h3);
    rd(REG_STATUS, 32'h0);
  endtask
  task automatic t_timeout;
    int n;
    logic early;
    early = 1'b0;
    wr(REG_CFG, 32'h1);
    wr(REG_TIMER_EN, 32'h4);
    send(2, mk(1'b0, 5'd0, 2'h3, 13'h0002, 1'b0));
    for (n = 0; n < 10 && alloc_q[2] !== 13'h0002; n++)
      step;
    chk("alloc_q", 32'h2, 32'(alloc_q[2]));
    // characters keep coming faster than the timeout
    for (n = 0; n < 39; n++)
    begin
      @(posedge sys_clk);
      char_tx[2] <= (n % 3 == 0);
      #1;
      early = early | spill_q[2];
    end
    chk("early spill", 32'h0, 32'(early));
    for (n = 0; n < 40 && spill_q[2] !== 1'b1; n++)
      step;
    chk("spill_q", 32'h1, 32'(spill_q[2]));
    chk("eep_q", 32'h2, 32'(eep_q));
  endtask
  task automatic t_block;
    logic early;
    int n;
    early = 1'b0;
    send(3, mk(1'b0, 5'd0, 2'h3, 13'h0002, 1'b0));
    send(2, mk(1'b0, 5'd0, 2'h3, 13'h0002, 1'b0));
    repeat (60)
    begin
      step;
      early = early | spill_q[3] | spill_q[2];
    end
    chk("alloc_q", 32'h2, 32'(alloc_q[3]));
    chk("alloc_q", 32'h0, 32'(alloc_q[2]));
    chk("stall spill", 32'h0, 32'(early));
    @(posedge sys_clk);
    pkt_done[3] <= 1'b1;
    @(posedge sys_clk);
    pkt_done[3] <= 1'b0;
    repeat (2) step;
    chk("alloc_q", 32'h0, 32'(alloc_q[3]));
    chk("alloc_q", 32'h2, 32'(alloc_q[2]));
    for (n = 0; n < 40 && spill_q[2] !== 1'b1; n++)
      step;
    chk("spill_q", 32'h1, 32'(spill_q[2]));
    chk("eep_q", 32'h2, 32'(eep_q));
  endtask
  task automatic t_norun(input rtc_hdr_t h, input logic ls);
    logic st, ep, al;
    {st, ep, al} = 3'b000;
    wr(REG_CFG, 32'({ls, 1'b0, 16'h0001}));
    send(2, h);
    for (int n = 0; n < 40 && spill_q[2] !== 1'b1; n++)
    begin
      st = st | link_start_q[4];
      ep = ep | (|eep_q);
      al = al | (|alloc_q[2]);
      step;
    end
    chk("spill_q", 32'h1, 32'(spill_q[2]));
    chk("eep_q", 32'h0, 32'(ep | (|eep_q)));
    chk("alloc_q", 32'h0, 32'(al));
    chk("link_start_q", 32'(ls), 32'(st));
  endtask
  task automatic t_scrub;
    int n;
    wr(REG_SCRUB, 32'h1);
    for (n = 0; n < 100 && scrub_strobe_q !== 1'b1; n++)
      step;
    chk("scrub_addr_q", 32'h0, 32'(scrub_addr_q));
    step;
    for (n = 1; n < 100 && scrub_strobe_q !== 1'b1; n++)
      step;
    chk("scrub_addr_q", 32'h1, 32'(scrub_addr_q));
    chk("scrub gap", 32'h1, 32'(n >= 14 && n <= 40));
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs;
    t_tc;
    t_bad;
    t_timeout;
    t_block;
    t_norun(mk(1'b1, 5'd4, 2'h0, 13'h0, 1'b0), 1'b1);
    t_norun(mk(1'b0, 5'd0, 2'h3, 13'h0013, 1'b0), 1'b0);
    t_norun(mk(1'b0, 5'd0, 2'h3, 13'h0010, 1'b0), 1'b1);
    t_scrub;
    conclude;
  end
  initial
  begin
    #200000;
    err_total++;
    conclude;
  end
endmodule
bind rtc_core rtc_core_asserts #(.SCRUB_PERIOD(SCRUB_PERIOD))
  u_rtc_core_asserts (.sys_clk(sys_clk), .reset(reset), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .tc_in_valid(tc_in_valid), .alloc_q(alloc_q),
  .spill_q(spill_q), .eep_q(eep_q), .invalid_addr_q(invalid_addr_q),
  .tc_out_valid_q(tc_out_valid_q), .tick_q(tick_q),
  .scrub_strobe_q(scrub_strobe_q), .scrub_addr_q(scrub_addr_q));
`default_nettype wire

// [hw/rtc_core.sv]
// switch core control: packet timeouts, autoscrub, time-code distribution
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rtc_core
#(
  parameter int SCRUB_PERIOD = rtc_pkg::SCRUB_PERIOD_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // per source port: header lookup and traffic events
  input wire logic [rtc_pkg::NPORT-1:0] hdr_valid,
  input wire rtc_pkg::rtc_hdr_t [rtc_pkg::NPORT-1:0] hdr,
  input wire logic [rtc_pkg::NPORT-1:0] char_tx,
  input wire logic [rtc_pkg::NPORT-1:0] pkt_done,
  // link state from the codecs, other clock domain
  input wire logic [rtc_pkg::NPORT-1:0] link_running,
  // routing results
  output logic [rtc_pkg::NPORT-1:0][rtc_pkg::NPORT-1:0] alloc_q,
  output logic [rtc_pkg::NPORT-1:0] spill_q,
  output logic [rtc_pkg::NPORT-1:0] eep_q,
  output logic [rtc_pkg::NPORT-1:0] link_start_q,
  output logic [rtc_pkg::NPORT-1:0] invalid_addr_q,
  // time-codes
  input wire logic [rtc_pkg::NPORT-1:0] tc_in_valid,
  input wire rtc_pkg::rtc_tc_t [rtc_pkg::NPORT-1:0] tc_in,
  output logic [rtc_pkg::NPORT-1:0] tc_out_valid_q,
  output rtc_pkg::rtc_tc_t tc_out_q,
  output logic tick_q,
  // table scrub strobe
  output logic scrub_strobe_q,
  output logic [7:0] scrub_addr_q
);
  import rtc_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] presc_q;
  logic timecode_flag_filter_q;
  logic ls_en_q;
  logic scrub_en_q;
  logic [NPORT-1:0] timer_en_q;
  logic [NPORT-1:0] timecode_port_enable_q;
  logic [15:0] tmo_q [NPORT];
  logic inv_flag_q;
  logic memory_error_flag_q;
  rtc_tc_t tcount_q;
  logic [7:0] scrub_addr;
  logic scrub_strobe;
  logic [31:0] rd_d;
  logic [NPORT-1:0] inv_evt;
  logic [NPORT-1:0] mem_evt;
  logic [7:0] tmo_idx;

  assign tmo_idx = (reg_addr - REG_TMO_BASE) >> 2;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      presc_q <= PRESC_RST;
      timecode_flag_filter_q <= 1'b0;
      ls_en_q <= 1'b0;
      scrub_en_q <= 1'b0;
      timer_en_q <= TIMER_EN_RST;
      timecode_port_enable_q <= TC_EN_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == REG_CFG)
      begin
        presc_q <= reg_wdata[15:0];
        timecode_flag_filter_q <= reg_wdata[CFG_TF_BIT];
        ls_en_q <= reg_wdata[CFG_LS_BIT];
      end
      if (reg_addr == REG_TIMER_EN)
        timer_en_q <= reg_wdata[NPORT-1:0];
      if (reg_addr == REG_TC_EN)
        timecode_port_enable_q <= reg_wdata[NPORT-1:0];
      if (reg_addr == REG_SCRUB)
        scrub_en_q <= reg_wdata[0];
    end
  end

  // per-port timeout in prescaler ticks, one timeout word per port
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++)
    begin : g_tmo
      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
          tmo_q[gp] <= TMO_RST;
        else if (reg_wr && reg_addr >= REG_TMO_BASE && tmo_idx == 8'(gp))
          tmo_q[gp] <= reg_wdata[15:0];
      end
    end
  endgenerate

  // sticky status: a new event in the clearing cycle survives
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      inv_flag_q <= 1'b0;
      memory_error_flag_q <= 1'b0;
    end
    else
    begin
      inv_flag_q <= (|inv_evt) || (inv_flag_q &&
        !(reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_INV_BIT]));
      memory_error_flag_q <= (|mem_evt) || (memory_error_flag_q &&
        !(reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_MEM_BIT]));
    end
  end

  always_comb
  begin
    rd_d = 32'h00000000;
    if (reg_addr == REG_CFG)
      rd_d = {14'h0000, ls_en_q, timecode_flag_filter_q, presc_q};
    else if (reg_addr == REG_TIMER_EN)
      rd_d[NPORT-1:0] = timer_en_q;
    else if (reg_addr == REG_TC_EN)
      rd_d[NPORT-1:0] = timecode_port_enable_q;
    else if (reg_addr == REG_TIMECODE)
      rd_d[7:0] = tcount_q;
    else if (reg_addr == REG_STATUS)
      rd_d[1:0] = {memory_error_flag_q, inv_flag_q};
    else if (reg_addr == REG_SCRUB)
      rd_d = {16'h0000, scrub_addr, 7'h00, scrub_en_q};
    else if (reg_addr >= REG_TMO_BASE && tmo_idx < 8'(NPORT))
      rd_d[15:0] = tmo_q[tmo_idx[3:0]];
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      reg_rdata_q <= 32'h00000000;
    else if (reg_rd)
      reg_rdata_q <= rd_d;
    else
      reg_rdata_q <= 32'h00000000;
  end

  // ------------------------------------------------------------
  // link state synchroniser and global prescaler
  // ------------------------------------------------------------
  logic [NPORT-1:0] run_meta_q;
  logic [NPORT-1:0] run_q;
  logic [15:0] pcnt_q;
  logic ptick;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      run_meta_q <= '0;
      run_q <= '0;
    end
    else
    begin
      run_meta_q <= link_running;
      run_q <= run_meta_q;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      pcnt_q <= 16'h0000;
    else if (ptick)
      pcnt_q <= 16'h0000;
    else
      pcnt_q <= pcnt_q + 16'h0001;
  end

  assign ptick = (pcnt_q >= presc_q);

  // ------------------------------------------------------------
  // per-source routing with timeouts
  // ------------------------------------------------------------
  rtc_state_t st_q [NPORT];
  logic [NPORT-1:0] cand_q [NPORT];
  logic [NPORT-1:0] dist_q;
  logic [NPORT-1:0] busy;
  logic [NPORT-1:0] taken;
  logic [NPORT-1:0] grant [NPORT];
  logic [NPORT-1:0] need;
  logic [NPORT-1:0] run;
  logic [NPORT-1:0] restart;
  logic [NPORT-1:0] expired;
  logic [NPORT-1:0] eep_d;
  logic [NPORT-1:0] ls_d;

  // configuration port 0 is a source like any other
  generate
    for (gp = 0; gp < NPORT; gp++)
    begin : g_tmr
      rtc_port_timer u_tmr
      (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(run[gp] && timer_en_q[gp]),
        .restart(restart[gp]),
        .tick(ptick),
        .timeout(tmo_q[gp]),
        .expired(expired[gp])
      );
    end
  endgenerate

  // lowest source wins a contested output in one cycle
  always_comb
  begin
    busy = '0;
    taken = '0;
    for (int s = 0; s < NPORT; s++)
      busy = busy | alloc_q[s];
    for (int s = 0; s < NPORT; s++)
    begin
      grant[s] = '0;
      if (st_q[s] == ST_WAIT)
      begin
        if (dist_q[s])
        begin
          if ((cand_q[s] & ~run_q) == '0 && (cand_q[s] & (busy | taken)) == '0)
            grant[s] = cand_q[s];
        end
        else
          grant[s] = rtc_lowest(cand_q[s] & run_q & ~busy & ~taken);
      end
      taken = taken | grant[s];
    end
  end

  // timer runs only on a link-down wait or during transmission
  always_comb
  begin
    ls_d = '0;
    for (int s = 0; s < NPORT; s++)
    begin
      need[s] = dist_q[s] ? |(cand_q[s] & ~run_q)
                          : ~|(cand_q[s] & run_q);
      run[s] = 1'b0;
      restart[s] = 1'b0;
      if (st_q[s] == ST_WAIT)
      begin
        run[s] = need[s];
        restart[s] = !need[s];
        if (need[s] && ls_en_q)
          ls_d = ls_d | (cand_q[s] & ~run_q);
      end
      else if (st_q[s] == ST_SEND)
      begin
        run[s] = 1'b1;
        restart[s] = char_tx[s];
      end
    end
  end

  always_comb
  begin
    eep_d = '0;
    for (int s = 0; s < NPORT; s++)
    begin
      inv_evt[s] = hdr_valid[s] && st_q[s] == ST_IDLE && rtc_invalid(hdr[s]);
      mem_evt[s] = hdr_valid[s] && st_q[s] == ST_IDLE && hdr[s].mem_err;
      if (st_q[s] == ST_SEND && expired[s])
        eep_d = eep_d | alloc_q[s];
    end
  end

  // with the timer off nothing expires, so a stall just blocks
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int s = 0; s < NPORT; s++)
      begin
        st_q[s] <= ST_IDLE;
        cand_q[s] <= '0;
        alloc_q[s] <= '0;
      end
      dist_q <= '0;
      spill_q <= '0;
    end
    else
    begin
      for (int s = 0; s < NPORT; s++)
      begin
        spill_q[s] <= 1'b0;
        unique case (st_q[s])
          ST_IDLE:
            if (hdr_valid[s])
            begin
              if (inv_evt[s] || mem_evt[s])
                spill_q[s] <= 1'b1;
              else
              begin
                cand_q[s] <= rtc_dest(hdr[s]);
                dist_q[s] <= hdr[s].setup[0];
                st_q[s] <= ST_WAIT;
              end
            end
          ST_WAIT:
            if (grant[s] != '0)
            begin
              alloc_q[s] <= grant[s];
              st_q[s] <= ST_SEND;
            end
            else if (expired[s])
            begin
              spill_q[s] <= 1'b1;
              st_q[s] <= ST_IDLE;
            end
          ST_SEND:
            if (pkt_done[s])
            begin
              alloc_q[s] <= '0;
              st_q[s] <= ST_IDLE;
            end
            else if (expired[s])
            begin
              spill_q[s] <= 1'b1;
              alloc_q[s] <= '0;
              st_q[s] <= ST_IDLE;
            end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      eep_q <= '0;
      link_start_q <= '0;
      invalid_addr_q <= '0;
    end
    else
    begin
      eep_q <= eep_d;
      link_start_q <= ls_d;
      invalid_addr_q <= inv_evt;
    end
  end

  // ------------------------------------------------------------
  // time-code distribution
  // ------------------------------------------------------------
  logic [NPORT-1:0] tc_ok;
  logic [NPORT-1:0] tc_sel;
  rtc_tc_t tc_pick;

  always_comb
  begin
    tc_pick = '0;
    for (int p = 0; p < NPORT; p++)
      tc_ok[p] = tc_in_valid[p] && timecode_port_enable_q[p] &&
                 (!timecode_flag_filter_q ||
                  tc_in[p].flags == TC_FLAGS_OK);
    tc_sel = rtc_lowest(tc_ok);
    for (int p = 0; p < NPORT; p++)
      if (tc_sel[p])
        tc_pick = tc_in[p];
  end

  // counter follows the lowest-numbered accepted code; only a +1 step is forwarded
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tcount_q <= '0;
      tick_q <= 1'b0;
      tc_out_valid_q <= '0;
      tc_out_q <= '0;
    end
    else
    begin
      tick_q <= 1'b0;
      tc_out_valid_q <= '0;
      if (tc_ok != '0)
      begin
        tcount_q <= tc_pick;
        if (tc_pick.count == tcount_q.count + TC_STEP)
        begin
          tick_q <= 1'b1;
          tc_out_q <= tc_pick;
          tc_out_valid_q <= timecode_port_enable_q & ~tc_sel;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // autoscrub, only in cycles with no header lookup
  // ------------------------------------------------------------
  rtc_scrubber #(.PERIOD(SCRUB_PERIOD)) u_scrub
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(scrub_en_q),
    .free_slot(~|hdr_valid),
    .strobe(scrub_strobe),
    .addr(scrub_addr)
  );

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      scrub_strobe_q <= 1'b0;
      scrub_addr_q <= 8'h00;
    end
    else
    begin
      scrub_strobe_q <= scrub_strobe;
      scrub_addr_q <= scrub_addr;
    end
  end
endmodule
`default_nettype wire

// [hw/rtc_pkg.sv]
// package for the router timeout, scrub and time-code control core
package rtc_pkg;
  localparam int NPORT = 13;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_TIMER_EN = 8'h04;
  localparam logic [7:0] REG_TC_EN = 8'h08;
  localparam logic [7:0] REG_TIMECODE = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_SCRUB = 8'h14;
  localparam logic [7:0] REG_TMO_BASE = 8'h40;
  localparam int CFG_TF_BIT = 16;
  localparam int CFG_LS_BIT = 17;
  localparam int ST_INV_BIT = 0;
  localparam int ST_MEM_BIT = 1;
  localparam logic [15:0] PRESC_RST = 16'h0063;
  localparam logic [15:0] TMO_RST = 16'h00FF;
  localparam logic [NPORT-1:0] TIMER_EN_RST = 13'h0000;
  localparam logic [NPORT-1:0] TC_EN_RST = 13'h1FFF;
  localparam int SCRUB_PERIOD_CYC = 67108864;
  localparam logic [7:0] SCRUB_LAST = 8'hFF;
  localparam logic [5:0] TC_STEP = 6'h01;
  localparam logic [1:0] TC_FLAGS_OK = 2'h0;

  // header lookup result presented by the routing table stage
  typedef struct packed {
    logic path;
    logic [4:0] port;
    logic rt_valid;
    logic ps_cfg;
    logic [NPORT-1:0] setup;
    logic mem_err;
  } rtc_hdr_t;

  typedef struct packed {
    logic [1:0] flags;
    logic [5:0] count;
  } rtc_tc_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEND} rtc_state_t;

  function automatic logic [NPORT-1:0] rtc_lowest(input logic [NPORT-1:0] m);
    logic [NPORT-1:0] r;
    r = m & (~m + 13'h0001);
    return r;
  endfunction

  function automatic logic rtc_invalid(input rtc_hdr_t h);
    logic bad;
    if (h.path)
      bad = (h.port >= 5'(NPORT));
    else
      bad = !h.rt_valid || !h.ps_cfg || (h.setup[NPORT-1:1] == '0);
    return bad;
  endfunction

  function automatic logic [NPORT-1:0] rtc_dest(input rtc_hdr_t h);
    logic [NPORT-1:0] m;
    m = h.ps_cfg ? {h.setup[NPORT-1:1], 1'b0} : '0;
    if (h.path)
      m = m | (13'h0001 << h.port);
    return m;
  endfunction
endpackage

// [hw/rtc_port_timer.sv]
// per-port packet timeout timer driven by the global prescaler tick
`timescale 1ns/1ps
`default_nettype none
module rtc_port_timer
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic tick,
  input wire logic [15:0] timeout,
  // status
  output logic expired
);
  import rtc_pkg::*;
  logic [15:0] cnt_q;

  // reload on restart or when idle so every wait starts a full period
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cnt_q <= 16'h0000;
    else if (restart || !run)
      cnt_q <= 16'h0000;
    else if (tick && !expired)
      cnt_q <= cnt_q + 16'h0001;
  end

  assign expired = run && (cnt_q == timeout);
endmodule
`default_nettype wire

// [hw/rtc_scrubber.sv]
// background refresh walker for routing table and port setup memories
`timescale 1ns/1ps
`default_nettype none
module rtc_scrubber
#(
  parameter int PERIOD = rtc_pkg::SCRUB_PERIOD_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  input wire logic enable,
  input wire logic free_slot,
  // memory strobe
  output logic strobe,
  output logic [7:0] addr
);
  import rtc_pkg::*;
  logic [26:0] wait_q;
  logic pend_q;
  logic [7:0] addr_q;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      wait_q <= 27'h0000000;
      pend_q <= 1'b0;
    end
    else if (!enable)
    begin
      wait_q <= 27'h0000000;
      pend_q <= 1'b0;
    end
    else if (pend_q)
    begin
      if (free_slot)
        pend_q <= 1'b0;
    end
    else if (wait_q == 27'(PERIOD - 1))
    begin
      wait_q <= 27'h0000000;
      pend_q <= 1'b1;
    end
    else
      wait_q <= wait_q + 27'h0000001;
  end

  // one read-rewrite of both tables at the same index per slot
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      addr_q <= 8'h00;
    else if (!enable)
      addr_q <= 8'h00;
    else if (pend_q && free_slot)
      addr_q <= (addr_q == SCRUB_LAST) ? 8'h00 : addr_q + 8'h01;
  end

  assign strobe = enable && pend_q && free_slot;
  assign addr = addr_q;
endmodule
`default_nettype wire
